// File: hw/spbm_port_end.sv
// spbm_port_end: byte-mode slave port with buffer word, flags and interrupt
// assumes: link pins from another domain, register port on clk_in
`timescale 1ns/100ps
module spbm_port_end
	import spbm_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	input  wire logic [31:0] reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic        peer_irq_in,
	input  wire logic        audio_irq_in,
	output logic [31:0]      reg_rdata_out,
	output logic             irq_out,
	spbm_link_if.per         link
);
	typedef enum logic [2:0] {
		PS_CMD  = 3'b001,
		PS_DATA = 3'b010,
		PS_SKIP = 3'b100
	} spbm_ps_type;

	spbm_ps_type state_r;
	logic [2:0]  sclk_sync_r;   // [0] first stage, [2] edge history
	logic [1:0]  cs_sync_r;
	logic [1:0]  mosi_sync_r;
	logic [3:0]  cnt_r;
	logic [6:0]  rx_r;
	logic [2:0]  op_r;
	logic [7:0]  tx_r;
	logic        miso_r;
	logic [31:0] buf0_r;
	logic [4:0]  flags_r;
	logic [4:0]  flags_nxt;
	logic [4:0]  en_r;
	logic        rise;
	logic        fall;
	logic        cs_idle;
	logic [7:0]  byte_in;
	logic        cmd_ok;
	logic        frame_end;
	logic        do_recv;
	logic        do_send;
	logic [4:0]  flag_set;
	logic        wr_ctrl;
	logic        wr_buf0;
	logic        wr_clr;
	logic        wr_en;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; the second stage is looked at, plus a third sclk stage for edges
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sclk_sync_r <= 3'h0;
			cs_sync_r   <= 2'h3;
			mosi_sync_r <= 2'h0;
		end else if (ce_in) begin
			sclk_sync_r <= {sclk_sync_r[1:0], link.sclk};
			cs_sync_r   <= {cs_sync_r[0], link.cs_n};
			mosi_sync_r <= {mosi_sync_r[0], link.mosi};
		end
	end

	// edge finding on the synchronised serial clock
	assign rise    = sclk_sync_r[1] && !sclk_sync_r[2];
	assign fall    = !sclk_sync_r[1] && sclk_sync_r[2];
	assign cs_idle = cs_sync_r[1];
	assign byte_in = {rx_r, mosi_sync_r[1]};

	// command byte: low three command bits and a zero address bit
	always_comb begin
		cmd_ok = 1'b0;
		if (!byte_in[0]) begin // address bit must be zero
			case (byte_in[3:1])
				SPBM_OP_RECV, SPBM_OP_SEND, SPBM_OP_DUPLEX: cmd_ok = 1'b1;
				default: cmd_ok = 1'b0;
			endcase
		end
	end

	assign frame_end = (state_r == PS_DATA) && rise && (cnt_r == 4'(SPBM_FRAME_BITS - 1))
		&& !cs_idle;
	assign do_recv   = (op_r == SPBM_OP_RECV) || (op_r == SPBM_OP_DUPLEX);
	assign do_send   = (op_r == SPBM_OP_SEND) || (op_r == SPBM_OP_DUPLEX);

	////////////////////////////////////////////////////////////////////////////
	// frame sequencer, sampled on rising serial clock
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r <= PS_CMD;
			cnt_r   <= 4'h0;
			rx_r    <= 7'h00;
			op_r    <= 3'h0;
		end else if (ce_in) begin
			if (cs_idle) begin
				state_r <= PS_CMD; // deselect always restarts the frame
				cnt_r   <= 4'h0;
			end else if (rise) begin
				rx_r  <= byte_in[6:0];
				cnt_r <= cnt_r + 4'h1;
				case (state_r)
					PS_CMD: begin
						if (cnt_r == 4'(SPBM_CMD_BITS - 1)) begin
							// unknown commands run out the frame with no effect
							state_r <= cmd_ok ? PS_DATA : PS_SKIP;
							op_r    <= byte_in[3:1];
						end
					end
					PS_DATA: begin
						if (cnt_r == 4'(SPBM_FRAME_BITS - 1)) begin
							state_r <= PS_SKIP; // extra bits wait for deselect
						end
					end
					PS_SKIP: cnt_r <= cnt_r;
					default: state_r <= PS_CMD;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// miso: buffer low byte shifted out on falling clock of the data byte
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_r   <= 8'h00;
			miso_r <= 1'b0;
		end else if (ce_in) begin
			if (cs_idle) begin
				miso_r <= 1'b0;
			end else if (fall && (state_r == PS_DATA) && do_send) begin
				if (cnt_r == 4'(SPBM_CMD_BITS)) begin
					miso_r <= buf0_r[7];
					tx_r   <= {buf0_r[6:0], 1'b0};
				end else begin
					miso_r <= tx_r[7];
					tx_r   <= {tx_r[6:0], 1'b0};
				end
			end
		end
	end

	assign link.miso = miso_r;

	////////////////////////////////////////////////////////////////////////////
	// register strobes
	always_comb begin
		wr_ctrl = 1'b0;
		wr_buf0 = 1'b0;
		wr_clr  = 1'b0;
		wr_en   = 1'b0;
		if (reg_wr_in) begin
			if (reg_addr_in == SPBM_OFS_CTRL) begin
				wr_ctrl = 1'b1;
			end else if (reg_addr_in == SPBM_OFS_BUF0) begin
				wr_buf0 = 1'b1;
			end else if (reg_addr_in == SPBM_OFS_CLR) begin
				wr_clr = 1'b1;
			end else if (reg_addr_in == SPBM_OFS_EN) begin
				wr_en = 1'b1;
			end
		end
	end

	// buffer word zero; a received byte wins over a same-cycle write
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			buf0_r <= SPBM_BUF0_RST;
		end else if (ce_in) begin
			if (wr_buf0) begin
				buf0_r <= reg_wdata_in;
			end
			if (frame_end && do_recv) begin
				buf0_r[7:0] <= byte_in; // received byte in low bits
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sticky flags: hardware set beats any software clear
	always_comb begin
		flag_set = 5'h00;
		if (frame_end) begin // only accepted commands reach here
			flag_set[SPBM_SRC_DONE]  = 1'b1;
			flag_set[SPBM_SRC_WRBUF] = do_recv;
			flag_set[SPBM_SRC_RDBUF] = do_send;
		end
		flags_nxt = flags_r;
		if (wr_ctrl) begin
			flags_nxt = flags_nxt & reg_wdata_in[4:0]; // zero clears
		end
		if (wr_clr) begin
			flags_nxt = flags_nxt & ~reg_wdata_in[4:0];
		end
		flags_nxt = flags_nxt | flag_set;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			flags_r <= SPBM_FLAGS_RST;
			en_r    <= SPBM_EN_RST;
		end else if (ce_in) begin
			flags_r <= flags_nxt;
			if (wr_ctrl) begin
				en_r <= reg_wdata_in[SPBM_EN_POS +: SPBM_NSRC];
			end else if (wr_en) begin
				en_r <= reg_wdata_in[SPBM_NSRC-1:0];
			end
		end
	end

	// interrupt follows next flag state so it matches the status read
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
		end else if (ce_in) begin
			irq_out <= |(flags_nxt & (wr_ctrl ? reg_wdata_in[SPBM_EN_POS +: SPBM_NSRC]
				: (wr_en ? reg_wdata_in[SPBM_NSRC-1:0] : en_r)));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data, valid only in the cycle after the read strobe
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else if (ce_in) begin
			reg_rdata_out <= 32'h0000_0000;
			if (reg_rd_in) begin
				if (reg_addr_in == SPBM_OFS_CTRL) begin
					reg_rdata_out <= {22'h0, en_r, flags_r};
				end else if (reg_addr_in == SPBM_OFS_BUF0) begin
					reg_rdata_out <= buf0_r;
				end else if (reg_addr_in == SPBM_OFS_STAT) begin
					reg_rdata_out <= {27'h0, flags_r};
				end else if (reg_addr_in == SPBM_OFS_EN) begin
					reg_rdata_out <= {27'h0, en_r};
				end else if (reg_addr_in == SPBM_OFS_SHARED) begin
					reg_rdata_out[SPBM_SH_PEER]  <= peer_irq_in;
					reg_rdata_out[SPBM_SH_OWN]   <= irq_out;
					reg_rdata_out[SPBM_SH_AUDIO] <= audio_irq_in;
				end
			end
		end
	end
endmodule // spbm_port_end

// File: hw/spbm_pkg.sv
// spbm_pkg: shared constants and types for the byte-mode serial port pair
// assumes: 40 MHz core clock on both ends, link pins carried by spbm_link_if
package spbm_pkg;
	////////////////////////////////////////////////////////////////////////////
	// register map of the slave end (byte addresses, one word each)
	localparam logic [31:0] SPBM_OFS_CTRL   = 32'h0000_0000;
	localparam logic [31:0] SPBM_OFS_BUF0   = 32'h0000_0004;
	localparam logic [31:0] SPBM_OFS_STAT   = 32'h0000_0008;
	localparam logic [31:0] SPBM_OFS_CLR    = 32'h0000_000c;
	localparam logic [31:0] SPBM_OFS_EN     = 32'h0000_0010;
	localparam logic [31:0] SPBM_OFS_SHARED = 32'h3ff0_0020;
	// field positions
	localparam int SPBM_NSRC       = 5;  // interrupt sources
	localparam int SPBM_EN_POS     = 5;  // enables sit above the flags in ctrl
	localparam int SPBM_SRC_DONE   = 0;  // transfer complete
	localparam int SPBM_SRC_RDBUF  = 3;  // master read the buffer
	localparam int SPBM_SRC_WRBUF  = 4;  // master wrote the buffer
	localparam int SPBM_SH_PEER    = 4;  // shared flags: first serial port
	localparam int SPBM_SH_OWN     = 7;  // shared flags: this (second) port
	localparam int SPBM_SH_AUDIO   = 9;  // shared flags: audio serial unit
	// reset values
	localparam logic [4:0]  SPBM_FLAGS_RST = 5'h00;
	localparam logic [4:0]  SPBM_EN_RST    = 5'h00;
	localparam logic [31:0] SPBM_BUF0_RST  = 32'h0000_0000;
	// frame layout and command codes (low three command bits)
	localparam int         SPBM_CMD_BITS   = 8;   // 7 command bits + 1 address bit
	localparam int         SPBM_FRAME_BITS = 16;
	localparam logic [2:0] SPBM_OP_RECV    = 3'h2;
	localparam logic [2:0] SPBM_OP_SEND    = 3'h3;
	localparam logic [2:0] SPBM_OP_DUPLEX  = 3'h6;
	// master timing: serial clock is a quarter of the core clock
	localparam int SPBM_CLK_DIV  = 4;
	localparam int SPBM_TAIL_CS  = 6;  // cycles after last bit before select rises
	localparam int SPBM_TAIL_END = 9;  // cycles after last bit until ready again
	localparam int SPBM_CAP_DLY  = 4;  // cycles from rising clock to miso capture
	// master request kinds
	typedef enum logic [1:0] {
		SPBM_KIND_BYTE  = 2'h0,
		SPBM_KIND_NINE  = 2'h1,
		SPBM_KIND_FRAME = 2'h2
	} spbm_kind_type;
endpackage

// File: hw/spbm_link_if.sv
// spbm_link_if: four-wire serial link between the master end and the slave end
// assumes: miso is driven by the slave only; the bench joins the two modports
`timescale 1ns/100ps
interface spbm_link_if;
	logic sclk;   // serial clock, idles low
	logic cs_n;   // chip select, active low
	logic mosi;   // master to slave data
	logic miso;   // slave to master data
	modport ctl (output sclk, output cs_n, output mosi, input miso);
	modport per (input sclk, input cs_n, input mosi, output miso);
endinterface

// File: hw/spbm_shift_engine.sv
// spbm_shift_engine: msb-first shifter driving the link at a quarter of clk_in
// assumes: start only while busy is low; miso arrives from another domain
`timescale 1ns/100ps
module spbm_shift_engine
	import spbm_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	input  wire logic        start_in,
	input  wire logic [4:0]  nbits_in,
	input  wire logic [15:0] word_in,
	input  wire logic        miso_in,
	output logic             busy_out,
	output logic             done_out,
	output logic [15:0]      rword_out,
	output logic             sclk_out,
	output logic             cs_n_out,
	output logic             mosi_out
);
	typedef enum logic [2:0] {
		SE_IDLE  = 3'b001,
		SE_SHIFT = 3'b010,
		SE_TAIL  = 3'b100
	} spbm_se_type;

	spbm_se_type state_r;
	logic [1:0]  phase_r;
	logic [4:0]  left_r;
	logic [15:0] tx_r;
	logic [3:0]  tail_r;
	logic [SPBM_CAP_DLY-1:0] rise_pipe_r;
	logic        miso_s1_r;
	logic        miso_s2_r;

	////////////////////////////////////////////////////////////////////////////
	// miso synchroniser
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			miso_s1_r <= 1'b0;
			miso_s2_r <= 1'b0;
		end else if (ce_in) begin
			miso_s1_r <= miso_in;
			miso_s2_r <= miso_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bit sequencer: clock high in phases 2..3, data changes as it falls
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r  <= SE_IDLE;
			phase_r  <= 2'h0;
			left_r   <= 5'h00;
			tx_r     <= 16'h0000;
			tail_r   <= 4'h0;
			sclk_out <= 1'b0;
			cs_n_out <= 1'b1;
			mosi_out <= 1'b0;
			busy_out <= 1'b0;
			done_out <= 1'b0;
		end else if (ce_in) begin
			done_out <= 1'b0;
			case (state_r)
				SE_IDLE: begin
					if (start_in) begin
						state_r  <= SE_SHIFT;
						phase_r  <= 2'h0;
						left_r   <= nbits_in;
						tx_r     <= {word_in[14:0], 1'b0};
						mosi_out <= word_in[15];
						cs_n_out <= 1'b0;
						busy_out <= 1'b1;
					end
				end
				SE_SHIFT: begin
					phase_r <= phase_r + 2'h1; // four core cycles per bit
					if (phase_r == 2'h1) begin
						sclk_out <= 1'b1;
					end else if (phase_r == 2'h3) begin
						sclk_out <= 1'b0;
						if (left_r == 5'h01) begin // exactly nbits shifted
							state_r <= SE_TAIL;
							tail_r  <= 4'h0;
						end else begin
							left_r   <= left_r - 5'h01;
							mosi_out <= tx_r[15];
							tx_r     <= {tx_r[14:0], 1'b0};
						end
					end
				end
				SE_TAIL: begin
					// hold select until the last miso bit has been captured
					tail_r <= tail_r + 4'h1;
					if (tail_r == 4'(SPBM_TAIL_CS)) begin
						cs_n_out <= 1'b1;
						mosi_out <= 1'b0;
					end
					if (tail_r == 4'(SPBM_TAIL_END)) begin
						state_r  <= SE_IDLE;
						busy_out <= 1'b0;
						done_out <= 1'b1;
					end
				end
				default: state_r <= SE_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// miso capture, delayed to cover the slave's oversampling round trip
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rise_pipe_r <= '0;
			rword_out   <= 16'h0000;
		end else if (ce_in) begin
			rise_pipe_r <= {rise_pipe_r[SPBM_CAP_DLY-2:0],
				(state_r == SE_SHIFT) && (phase_r == 2'h1)};
			if (rise_pipe_r[SPBM_CAP_DLY-1]) begin
				rword_out <= {rword_out[14:0], miso_s2_r};
			end else if (start_in && (state_r == SE_IDLE)) begin
				rword_out <= 16'h0000;
			end
		end
	end
endmodule // spbm_shift_engine

// File: hw/spbm_host_end.sv
// spbm_host_end: external master driving the link; also sends raw bytes and
// 9-bit display words. assumes: requests come from logic on clk_in
`timescale 1ns/100ps
module spbm_host_end
	import spbm_pkg::*;
(
	input  wire logic          clk_in,
	input  wire logic          rst_in,
	input  wire logic          ce_in,
	input  wire logic          req_in,
	input  wire spbm_kind_type kind_in,
	input  wire logic [7:0]    first_in,
	input  wire logic [7:0]    data_in,
	input  wire logic [7:0]    high_in,
	output logic               busy_out,
	output logic               done_out,
	output logic [7:0]         rdata_out,
	spbm_link_if.ctl           link
);
	logic        start;
	logic [4:0]  nbits;
	logic [15:0] word;
	logic [15:0] rword;

	////////////////////////////////////////////////////////////////////////////
	// request to shifter word, msb aligned
	always_comb begin
		start = req_in && !busy_out;
		nbits = 5'(SPBM_CMD_BITS);
		word  = {data_in, 8'h00};
		case (kind_in)
			SPBM_KIND_NINE: begin
				nbits = 5'(SPBM_CMD_BITS + 1);
				word  = {(|high_in), data_in, 7'h00}; // ninth bit then low byte
			end
			SPBM_KIND_FRAME: begin
				nbits = 5'(SPBM_FRAME_BITS); // command, zero address, data
				word  = {first_in[7:1], 1'b0, data_in}; // address bit forced low
			end
			default: begin
				nbits = 5'(SPBM_CMD_BITS); // one plain byte
				word  = {data_in, 8'h00};
			end
		endcase
	end

	// one engine serves all three kinds; mode 0 on the wire
	spbm_shift_engine i_spbm_shift_engine (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.ce_in     (ce_in),
		.start_in  (start),
		.nbits_in  (nbits),
		.word_in   (word),
		.miso_in   (link.miso),
		.busy_out  (busy_out),
		.done_out  (done_out),
		.rword_out (rword),
		.sclk_out  (link.sclk),
		.cs_n_out  (link.cs_n),
		.mosi_out  (link.mosi)
	);

	// answer is the second byte of a frame, the last byte otherwise
	assign rdata_out = rword[7:0];
endmodule // spbm_host_end

// File: verif/spbm_link_props.sv
// spbm_link_props: timing and framing checks on the wires of the first link
// assumes: both ends run on clk_in; instantiated beside the interface
`timescale 1ns/100ps
module spbm_link_props (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic mosi,
	input  wire logic miso
);
	logic       sclk_q_r;    // serial clock one cycle ago
	logic [4:0] rise_cnt_r;  // serial rising edges seen in this frame

	////////////////////////////////////////////////////////////////////////////
	// count rises per frame; a deselected link restarts the count
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sclk_q_r   <= 1'b0;
			rise_cnt_r <= 5'h00;
		end else begin
			sclk_q_r <= sclk;
			if (cs_n)
				rise_cnt_r <= 5'h00;
			else if (sclk && !sclk_q_r)
				rise_cnt_r <= rise_cnt_r + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// one clock domain, so clocking and disable are given once
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_idle_low; cs_n |-> !sclk; endproperty
	property p_high_two; $rose(sclk) |-> ##1 sclk ##1 !sclk; endproperty
	property p_low_two; $fell(sclk) |-> ##1 !sclk; endproperty
	property p_mosi_hold; sclk |-> $stable(mosi); endproperty
	property p_cs_lead; $fell(cs_n) |-> !sclk ##1 !sclk ##1 sclk; endproperty
	property p_frame_len;
		$rose(cs_n) |-> (rise_cnt_r == 5'h08 || rise_cnt_r == 5'h09 || rise_cnt_r == 5'h10);
	endproperty
	property p_no_stall; !cs_n && !sclk |-> ##[1:8] (sclk || cs_n); endproperty
	property p_gap; $rose(cs_n) |-> cs_n[*3]; endproperty
	property p_tail; $rose(cs_n) |-> $past(sclk, 8) && !$past(sclk, 7); endproperty

	a_idle_low: assert property (p_idle_low) else $error("serial clock high while deselected");
	a_high_two: assert property (p_high_two) else $error("serial clock high phase not 2 cycles");
	a_low_two: assert property (p_low_two) else $error("serial clock low phase too short");
	a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while clock high");
	a_cs_lead: assert property (p_cs_lead) else $error("first rise not 2 cycles after select");
	a_frame_len: assert property (p_frame_len) else $error("frame not 8, 9 or 16 bits");
	a_no_stall: assert property (p_no_stall) else $error("serial clock stalled in frame");
	a_gap: assert property (p_gap) else $error("select high under 3 cycles");
	a_tail: assert property (p_tail) else $error("select rose off its tail slot");

	// main traffic kinds seen on the wire
	c_frame: cover property ($rose(cs_n) && rise_cnt_r == 5'h10);
	c_nine: cover property ($rose(cs_n) && rise_cnt_r == 5'h09);
	c_byte: cover property ($rose(cs_n) && rise_cnt_r == 5'h08);
	c_miso: cover property (sclk && miso);
endmodule // spbm_link_props

// File: verif/test_spi_byte_mode_slave_master.sv
// test_spi_byte_mode_slave_master: master end against slave end on one link,
// and a bench driver that breaks framing on a second slave's link
// assumes: spbm_pkg, spbm_link_if, both ends and spbm_link_props compiled first
`timescale 1ns/100ps
module test_spi_byte_mode_slave_master import spbm_pkg::*;;
	logic          clk, rst, req, wr_s, rd_s, peer, audio, ce;
	logic          h_busy, h_done, irq1, irq2, sclk_q, cs_q, ok;
	spbm_kind_type kind;
	logic [7:0]    first, data, high, h_rdata, mon_n;
	logic [15:0]   mon_w;
	logic [31:0]   addr, wdata, rdata1, rdata2, v1, v2, b;
	logic [31:0]   seed = 32'h1e;
	logic [31:0]   ofs [5] = '{SPBM_OFS_CTRL, SPBM_OFS_BUF0, SPBM_OFS_STAT, SPBM_OFS_EN, 32'h40};
	int            n_fail, total_checks;

	spbm_link_if i_link ();
	spbm_link_if i_link_2 ();
	spbm_host_end i_spbm_host_end (.clk_in(clk), .rst_in(rst), .ce_in(1'b1), .req_in(req),
		.kind_in(kind), .first_in(first), .data_in(data), .high_in(high), .busy_out(h_busy),
		.done_out(h_done), .rdata_out(h_rdata), .link(i_link.ctl));
	spbm_port_end i_spbm_port_end (.clk_in(clk), .rst_in(rst), .ce_in(ce), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .peer_irq_in(peer),
		.audio_irq_in(audio), .reg_rdata_out(rdata1), .irq_out(irq1), .link(i_link.per));
	spbm_port_end i_spbm_port_end_2 (.clk_in(clk), .rst_in(rst), .ce_in(1'b1),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
		.peer_irq_in(peer), .audio_irq_in(audio), .reg_rdata_out(rdata2), .irq_out(irq2),
		.link(i_link_2.per));
	spbm_link_props i_spbm_link_props (.clk_in(clk), .rst_in(rst), .sclk(i_link.sclk),
		.cs_n(i_link.cs_n), .mosi(i_link.mosi), .miso(i_link.miso));

	////////////////////////////////////////////////////////////////////////////
	// 40 MHz core clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// wire monitor: shift mosi in at each serial rise, cleared at select
	always @(posedge clk) begin
		sclk_q <= i_link.sclk;
		cs_q <= i_link.cs_n;
		if (cs_q && !i_link.cs_n) begin
			mon_n <= 8'h00;
			mon_w <= 16'h0000;
		end else if (!i_link.cs_n && i_link.sclk && !sclk_q) begin
			mon_n <= mon_n + 8'h01;
			mon_w <= {mon_w[14:0], i_link.mosi};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// xorshift source, fixed start so every run repeats
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// flags a frame should leave behind: done, buffer read, buffer written
	function automatic logic [31:0] exp_stat(input logic [2:0] op);
		case (op)
			SPBM_OP_RECV: exp_stat = 32'h11;
			SPBM_OP_SEND: exp_stat = 32'h09;
			SPBM_OP_DUPLEX: exp_stat = 32'h19;
			default: exp_stat = 32'h00;
		endcase
	endfunction

	function automatic logic [31:0] exp_buf(input logic [2:0] op, input logic [31:0] bv,
		input logic [7:0] dv);
		exp_buf = (op == SPBM_OP_RECV || op == SPBM_OP_DUPLEX) ? {bv[31:8], dv} : bv;
	endfunction

	task report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// register port: single-cycle strobes, read data the cycle after
	task wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task rd(input logic [31:0] a, output logic [31:0] r1, output logic [31:0] r2);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		r1 = rdata1;
		r2 = rdata2;
	endtask

	// one master request, bounded wait for done, then slack for slave flags
	task host(input spbm_kind_type k, input logic [7:0] f, input logic [7:0] d,
		input logic [7:0] h);
		int w;
		@(posedge clk);
		kind <= k;
		first <= f;
		data <= d;
		high <= h;
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		#1;
		chk(32'(h_busy), 32'h1);
		for (w = 0; w < 300 && h_done !== 1'b1; w++) begin
			@(posedge clk);
			#1;
		end
		repeat (3) @(posedge clk);
		if (w == 300) begin
			n_fail++;
			report_and_stop();
		end
	endtask

	// bench master on the second link, nb bits; short nb aborts mid frame
	task bb(input logic [15:0] w, input int nb);
		int k;
		@(posedge clk);
		i_link_2.cs_n <= 1'b0;
		for (k = 0; k < nb; k++) begin
			i_link_2.mosi <= w[15-k];
			repeat (4) @(posedge clk);
			i_link_2.sclk <= 1'b1;
			repeat (4) @(posedge clk);
			i_link_2.sclk <= 1'b0;
		end
		repeat (2) @(posedge clk);
		i_link_2.cs_n <= 1'b1;
		i_link_2.mosi <= ~i_link_2.mosi;
		repeat (8) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		int i;
		logic [2:0] op;
		logic [7:0] f, d, h;
		{rst, req, wr_s, rd_s, peer, audio, ce} = 7'h41;
		kind = SPBM_KIND_BYTE;
		{first, data, high} = 24'h000000;
		{addr, wdata} = 64'h0;
		{i_link_2.cs_n, i_link_2.sclk, i_link_2.mosi} = 3'h4;
		n_fail = 0;
		total_checks = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// reset values, a write to the read-only flags and an unmapped read
		wr(SPBM_OFS_STAT, 32'h1f);
		for (i = 0; i < 5; i++) begin
			rd(ofs[i], v1, v2);
			chk(v1, 32'h0);
		end
		wr(SPBM_OFS_CTRL, 32'h3e0);
		rd(SPBM_OFS_EN, v1, v2);
		chk(v1, 32'h1f);
		// every low command code, then random legal ones
		for (i = 0; i < 12; i++) begin
			b = rnd();
			op = (i < 8) ? i[2:0] : (b[9] ? SPBM_OP_RECV : SPBM_OP_DUPLEX);
			f = {b[15:12], op, b[16]};
			d = b[31:24] ^ 8'h5a;
			peer <= b[17];
			audio <= b[18];
			ok = (exp_stat(op) != 32'h0);
			wr(SPBM_OFS_CLR, 32'h1f);
			wr(SPBM_OFS_BUF0, b);
			host(SPBM_KIND_FRAME, f, d, 8'h00);
			chk(32'(mon_n), 32'h10);
			chk(32'(mon_w), {16'h0, f[7:1], 1'b0, d});
			rd(SPBM_OFS_STAT, v1, v2);
			chk(v1, exp_stat(op));
			rd(SPBM_OFS_BUF0, v1, v2);
			chk(v1, exp_buf(op, b, d));
			if (op == SPBM_OP_SEND || op == SPBM_OP_DUPLEX)
				chk(32'(h_rdata), 32'(b[7:0]));
			chk(32'(irq1), 32'(ok));
			rd(SPBM_OFS_SHARED, v1, v2);
			chk(v1, {22'h0, b[18], 1'b0, ok, 2'h0, b[17], 4'h0});
		end
		// flags cleared through control, enables kept, then both cleared
		wr(SPBM_OFS_CTRL, 32'h3e0);
		rd(SPBM_OFS_STAT, v1, v2);
		chk(v1 | 32'(irq1), 32'h0);
		host(SPBM_KIND_FRAME, 8'h04, 8'h3c, 8'h00);
		chk(32'(irq1), 32'h1);
		wr(SPBM_OFS_CTRL, 32'h0);
		rd(SPBM_OFS_EN, v1, v2);
		chk(v1 | 32'(irq1), 32'h0);
		// frozen first slave must ignore a write that the second slave takes
		ce <= 1'b0;
		wr(SPBM_OFS_EN, 32'h11);
		ce <= 1'b1;
		rd(SPBM_OFS_EN, v1, v2);
		chk(v1, 32'h0);
		chk(v2, 32'h11);
		// display words and single bytes; slave must ignore the short frames
		for (i = 0; i < 4; i++) begin
			b = rnd();
			h = (i == 0) ? 8'h00 : b[15:8];
			host(SPBM_KIND_NINE, b[23:16], b[7:0], h);
			chk({mon_n, 7'h0, mon_w[8:0]}, {8'h09, 7'h0, |h, b[7:0]});
			host(SPBM_KIND_BYTE, 8'h00, b[31:24], 8'h00);
			chk({mon_n, mon_w}, {8'h08, 8'h00, b[31:24]});
		end
		rd(SPBM_OFS_STAT, v1, v2);
		chk(v1, 32'h0);
		// second slave: address bit set, aborted frame, then a clean write
		b = rnd();
		bb({8'h05, b[7:0]}, 16);
		rd(SPBM_OFS_STAT, v1, v2);
		chk(v2, 32'h0);
		bb({8'h04, b[7:0]}, 10);
		rd(SPBM_OFS_STAT, v1, v2);
		chk(v2, 32'h0);
		bb({8'h04, b[7:0]}, 16);
		rd(SPBM_OFS_STAT, v1, v2);
		chk(v2, 32'h11);
		chk(32'(irq2), 32'h1);
		rd(SPBM_OFS_BUF0, v1, v2);
		chk(v2 & 32'hff, 32'(b[7:0]));
		report_and_stop();
	end
endmodule // test_spi_byte_mode_slave_master
